// *** frac_defs.vh ***
`ifndef FRAC_DEFS_VH
`define FRAC_DEFS_VH

// Command codes written to the flash command register.
`define FRAC_CMD_RESET        8'hFF
`define FRAC_CMD_PROG_SETUP   8'h40
`define FRAC_CMD_ID_A         8'h90
`define FRAC_CMD_ID_B         8'h80
`define FRAC_CMD_READ         8'h00

// Identifier addresses.
`define FRAC_ADDR_MFR_ID      17'h00000
`define FRAC_ADDR_DEV_ID      17'h00001

// Widths.
`define FRAC_AW               17
`define FRAC_DW               8

// Bus timing in cycles of the 10 ns clock: 30 ns setup, 50 ns write strobe,
// 80 ns read strobe and 20 ns recovery.
`define FRAC_SETUP_CYC        4'h3
`define FRAC_PULSE_CYC        4'h5
`define FRAC_READ_CYC         4'h8
`define FRAC_RECOVER_CYC      4'h2
`define FRAC_CNT_LAST         4'h1
`define FRAC_CNT_W            4

// Host operations requested on the user port.
`define FRAC_OP_W             3
`define FRAC_OP_READ          3'h0
`define FRAC_OP_WRITE         3'h1
`define FRAC_OP_RESET         3'h2
`define FRAC_OP_READ_ID       3'h3
`define FRAC_OP_PROGRAM       3'h4

`endif

// *** frac_bus_cycle.v ***
`timescale 1ns/100ps
`default_nettype none
`include "frac_defs.vh"

module frac_bus_cycle (
   // Clock and reset.
   input  wire                     clk_i,
   input  wire                     rst_n_i,
   // Cycle request.
   input  wire                     start_i,
   input  wire                     write_i,
   input  wire [`FRAC_AW-1:0]      addr_i,
   input  wire [`FRAC_DW-1:0]      data_i,
   output reg                      done_o,
   output reg  [`FRAC_DW-1:0]      rdata_o,
   // Flash pins.
   output reg  [`FRAC_AW-1:0]      addr_o,
   output reg  [`FRAC_DW-1:0]      dq_o,
   output reg                      dq_oe_o,
   input  wire [`FRAC_DW-1:0]      dq_i,
   output reg                      ce_n_o,
   output reg                      oe_n_o,
   output reg                      we_n_o
);

   localparam S_IDLE  = 2'h0;
   localparam S_SETUP = 2'h1;
   localparam S_PULSE = 2'h2;
   localparam S_REC   = 2'h3;

   reg [1:0]             state_reg;
   reg [`FRAC_CNT_W-1:0] cnt_reg;
   reg                   wr_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Address is set before the strobe falls and data stays through its rise.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= S_IDLE;
         cnt_reg   <= {`FRAC_CNT_W{1'b0}};
         wr_reg    <= 1'b0;
         done_o    <= 1'b0;
         rdata_o   <= {`FRAC_DW{1'b0}};
         addr_o    <= {`FRAC_AW{1'b0}};
         dq_o      <= {`FRAC_DW{1'b0}};
         dq_oe_o   <= 1'b0;
         ce_n_o    <= 1'b1;
         oe_n_o    <= 1'b1;
         we_n_o    <= 1'b1;
      end else begin
         done_o <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (start_i) begin
                  wr_reg    <= write_i;
                  addr_o    <= addr_i;
                  dq_o      <= data_i;
                  dq_oe_o   <= write_i;
                  ce_n_o    <= 1'b0;
                  cnt_reg   <= `FRAC_SETUP_CYC;
                  state_reg <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_reg <= `FRAC_CNT_LAST) begin
                  we_n_o    <= ~wr_reg;
                  oe_n_o    <= wr_reg;
                  cnt_reg   <= wr_reg ? `FRAC_PULSE_CYC : `FRAC_READ_CYC;
                  state_reg <= S_PULSE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            S_PULSE: begin
               if (cnt_reg <= `FRAC_CNT_LAST) begin
                  if (!wr_reg) begin
                     rdata_o <= dq_i;
                  end
                  we_n_o    <= 1'b1;
                  oe_n_o    <= 1'b1;
                  cnt_reg   <= `FRAC_RECOVER_CYC;
                  state_reg <= S_REC;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            S_REC: begin
               if (cnt_reg <= `FRAC_CNT_LAST) begin
                  ce_n_o    <= 1'b1;
                  dq_oe_o   <= 1'b0;
                  done_o    <= 1'b1;
                  state_reg <= S_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

endmodule // frac_bus_cycle
`default_nettype wire

// *** frac_ctrl.v ***
// Function
// - After 40h, write reset twice.
// - Otherwise one reset write suffices.
// - Reset operation always issues two reset writes; a plain write of FFh issues one.
// - 80h or 90h enters identifier readout.
// - Identifier readout ends on valid command.
`timescale 1ns/100ps
`default_nettype none
`include "frac_defs.vh"

module frac_ctrl (
   // Clock and reset.
   input  wire                     SYS_CLK_I,
   input  wire                     RST_N_I,
   // User request port.
   input  wire                     REQ_VALID_I,
   input  wire [`FRAC_OP_W-1:0]    REQ_OP_I,
   input  wire [`FRAC_AW-1:0]      REQ_ADDR_I,
   input  wire [`FRAC_DW-1:0]      REQ_DATA_I,
   output reg                      REQ_READY_O,
   // User answer port.
   output reg                      RSP_VALID_O,
   output reg  [`FRAC_DW-1:0]      RSP_DATA_O,
   output reg  [`FRAC_DW-1:0]      RSP_DEV_ID_O,
   output reg                      ID_MODE_O,
   // Flash pins.
   output wire [`FRAC_AW-1:0]      FL_ADDR_O,
   output wire [`FRAC_DW-1:0]      FL_DQ_O,
   output wire                     FL_DQ_OE_O,
   input  wire [`FRAC_DW-1:0]      FL_DQ_I,
   output wire                     FL_CE_N_O,
   output wire                     FL_OE_N_O,
   output wire                     FL_WE_N_O
);

   localparam S_IDLE = 3'h0;
   localparam S_RST1 = 3'h1;
   localparam S_RST2 = 3'h2;
   localparam S_ID0  = 3'h3;
   localparam S_ID1  = 3'h4;
   localparam S_PSET = 3'h5;
   localparam S_PDAT = 3'h6;
   localparam S_ONE  = 3'h7;

   reg [2:0]            state_reg;
   reg                  start_reg;
   reg                  wr_reg;
   reg [`FRAC_AW-1:0]   addr_reg;
   reg [`FRAC_DW-1:0]   data_reg;
   reg [`FRAC_AW-1:0]   req_addr_reg;
   reg [`FRAC_DW-1:0]   req_data_reg;
   reg [`FRAC_OP_W-1:0] op_reg;
   wire                 done;
   wire [`FRAC_DW-1:0]  rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin sequencer for one read or write cycle.
   frac_bus_cycle u_cycle (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .start_i (start_reg),
      .write_i (wr_reg),
      .addr_i  (addr_reg),
      .data_i  (data_reg),
      .done_o  (done),
      .rdata_o (rdata),
      .addr_o  (FL_ADDR_O),
      .dq_o    (FL_DQ_O),
      .dq_oe_o (FL_DQ_OE_O),
      .dq_i    (FL_DQ_I),
      .ce_n_o  (FL_CE_N_O),
      .oe_n_o  (FL_OE_N_O),
      .we_n_o  (FL_WE_N_O)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Operation sequencer.
   always @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state_reg    <= S_IDLE;
         start_reg    <= 1'b0;
         wr_reg       <= 1'b0;
         addr_reg     <= {`FRAC_AW{1'b0}};
         data_reg     <= {`FRAC_DW{1'b0}};
         req_addr_reg <= {`FRAC_AW{1'b0}};
         req_data_reg <= {`FRAC_DW{1'b0}};
         op_reg       <= `FRAC_OP_READ;
         REQ_READY_O  <= 1'b1;
         RSP_VALID_O  <= 1'b0;
         RSP_DATA_O   <= {`FRAC_DW{1'b0}};
         RSP_DEV_ID_O <= {`FRAC_DW{1'b0}};
         ID_MODE_O    <= 1'b0;
      end else begin
         start_reg   <= 1'b0;
         RSP_VALID_O <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (REQ_VALID_I && REQ_READY_O) begin
                  REQ_READY_O  <= 1'b0;
                  op_reg       <= REQ_OP_I;
                  req_addr_reg <= REQ_ADDR_I;
                  req_data_reg <= REQ_DATA_I;
                  start_reg    <= 1'b1;
                  addr_reg     <= REQ_ADDR_I;
                  data_reg     <= REQ_DATA_I;
                  case (REQ_OP_I)
                     `FRAC_OP_RESET: begin
                        wr_reg    <= 1'b1;
                        data_reg  <= `FRAC_CMD_RESET;
                        state_reg <= S_RST1;
                     end
                     `FRAC_OP_READ_ID: begin
                        wr_reg    <= 1'b1;
                        data_reg  <= `FRAC_CMD_ID_A;
                        state_reg <= S_ID0;
                     end
                     `FRAC_OP_PROGRAM: begin
                        wr_reg    <= 1'b1;
                        data_reg  <= `FRAC_CMD_PROG_SETUP;
                        state_reg <= S_PSET;
                     end
                     `FRAC_OP_WRITE: begin
                        wr_reg    <= 1'b1;
                        state_reg <= S_ONE;
                     end
                     default: begin
                        wr_reg    <= 1'b0;
                        state_reg <= S_ONE;
                     end
                  endcase
               end
            end
            S_RST1: begin
               if (done) begin
                  start_reg <= 1'b1;
                  data_reg  <= `FRAC_CMD_RESET;
                  state_reg <= S_RST2;
               end
            end
            S_RST2: begin
               if (done) begin
                  ID_MODE_O   <= 1'b0;
                  RSP_VALID_O <= 1'b1;
                  REQ_READY_O <= 1'b1;
                  state_reg   <= S_IDLE;
               end
            end
            S_ID0: begin
               if (done) begin
                  ID_MODE_O <= 1'b1;
                  start_reg <= 1'b1;
                  wr_reg    <= 1'b0;
                  addr_reg  <= `FRAC_ADDR_MFR_ID;
                  state_reg <= S_ID1;
               end
            end
            S_ID1: begin
               if (done && addr_reg == `FRAC_ADDR_MFR_ID) begin
                  RSP_DATA_O <= rdata;
                  start_reg  <= 1'b1;
                  addr_reg   <= `FRAC_ADDR_DEV_ID;
               end else if (done) begin
                  RSP_DEV_ID_O <= rdata;
                  RSP_VALID_O  <= 1'b1;
                  REQ_READY_O  <= 1'b1;
                  state_reg    <= S_IDLE;
               end
            end
            S_PSET: begin
               if (done) begin
                  start_reg <= 1'b1;
                  addr_reg  <= req_addr_reg;
                  data_reg  <= req_data_reg;
                  state_reg <= S_PDAT;
               end
            end
            S_PDAT: begin
               if (done) begin
                  ID_MODE_O   <= 1'b0;
                  RSP_VALID_O <= 1'b1;
                  REQ_READY_O <= 1'b1;
                  state_reg   <= S_IDLE;
               end
            end
            S_ONE: begin
               if (done) begin
                  if (op_reg == `FRAC_OP_WRITE) begin
                     if (req_data_reg == `FRAC_CMD_ID_A || req_data_reg == `FRAC_CMD_ID_B) begin
                        ID_MODE_O <= 1'b1;
                     end else if (req_data_reg == `FRAC_CMD_RESET || req_data_reg == `FRAC_CMD_READ ||
                                  req_data_reg == `FRAC_CMD_PROG_SETUP) begin
                        ID_MODE_O <= 1'b0;
                     end
                  end else begin
                     RSP_DATA_O <= rdata;
                  end
                  RSP_VALID_O <= 1'b1;
                  REQ_READY_O <= 1'b1;
                  state_reg   <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
      end
   end

endmodule // frac_ctrl
`default_nettype wire

// *** frac_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "frac_defs.vh"
module frac_props (
   // Clock and reset.
   input wire logic                SYS_CLK_I,
   input wire logic                RST_N_I,
   // User side.
   input wire logic                REQ_VALID_I,
   input wire logic                REQ_READY_O,
   input wire logic                RSP_VALID_O,
   input wire logic                ID_MODE_O,
   // Flash pins.
   input wire logic [`FRAC_AW-1:0] FL_ADDR_O,
   input wire logic [`FRAC_DW-1:0] FL_DQ_O,
   input wire logic                FL_DQ_OE_O,
   input wire logic                FL_CE_N_O,
   input wire logic                FL_OE_N_O,
   input wire logic                FL_WE_N_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   chk_no_strobe_clash: assert property (!(!FL_WE_N_O && !FL_OE_N_O)) else $error("both strobes low");
   chk_we_needs_ce: assert property (!FL_WE_N_O |-> !FL_CE_N_O && FL_DQ_OE_O) else $error("write strobe bad");
   chk_oe_needs_ce: assert property (!FL_OE_N_O |-> !FL_CE_N_O && !FL_DQ_OE_O) else $error("read strobe bad");
   chk_we_pulse_len: assert property ($fell(FL_WE_N_O) |-> (!FL_WE_N_O)[*5] ##1 FL_WE_N_O) else $error("write pulse length");
   chk_addr_data_hold: assert property (!FL_WE_N_O && !$past(FL_WE_N_O) |-> $stable(FL_ADDR_O) && $stable(FL_DQ_O)) else $error("bus moved in strobe");
   chk_busy_after_take: assert property (REQ_VALID_I && REQ_READY_O |=> !REQ_READY_O) else $error("ready stayed high");
   chk_answer_bound: assert property (REQ_VALID_I && REQ_READY_O |-> ##[10:60] RSP_VALID_O) else $error("no answer");
   chk_rsp_single: assert property (RSP_VALID_O |-> REQ_READY_O ##1 !RSP_VALID_O) else $error("answer pulse bad");
   chk_id_entry: assert property ($rose(FL_WE_N_O) && (FL_DQ_O == `FRAC_CMD_ID_A || FL_DQ_O == `FRAC_CMD_ID_B)
      |-> ##[0:40] ID_MODE_O) else $error("id mode not set");
   chk_id_exit: assert property ($rose(FL_WE_N_O) && FL_DQ_O == `FRAC_CMD_RESET |-> ##[0:40] !ID_MODE_O)
      else $error("id mode not cleared");
   cov_write: cover property ($rose(FL_WE_N_O));
   cov_read: cover property ($rose(FL_OE_N_O));
   cov_id: cover property ($rose(ID_MODE_O));
endmodule // frac_props
`default_nettype wire

// *** frac_flash_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module frac_flash_model #(
   parameter logic [7:0] MFR_ID = 8'hA7, // Arbitrary value.
   parameter logic [7:0] DEV_ID = 8'h3C  // Arbitrary value.
) (
   // Flash pins.
   input wire logic [16:0] addr_i,
   input wire logic [7:0]  dq_i,
   input wire logic        ce_n_i,
   input wire logic        oe_n_i,
   input wire logic        we_n_i,
   output logic [7:0]      dq_o
);
   logic [7:0]  mem [0:131071];
   logic [1:0]  st;
   logic [16:0] wa;
   logic [7:0]  last;
   initial begin
      for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'hA5;
      st = 2'd0;
      last = 8'h00;
   end
   always @(negedge we_n_i) if (!ce_n_i) wa = addr_i;
   always @(posedge we_n_i) begin
      if (!ce_n_i) begin
         if (st == 2'd1) begin
            mem[wa] = mem[wa] & dq_i;
            st = 2'd3;
         end else if (dq_i == 8'hFF || dq_i == 8'h00) st = 2'd0;
         else if (dq_i == 8'h40) st = 2'd1;
         else if (dq_i == 8'h80 || dq_i == 8'h90) st = 2'd2;
      end // Other codes keep the state.
   end
   always @* begin
      if (!ce_n_i && !oe_n_i) begin
         if (st == 2'd2 && addr_i == 17'h00000) last = MFR_ID;
         else if (st == 2'd2 && addr_i == 17'h00001) last = DEV_ID;
         else last = mem[addr_i];
         dq_o = last;
      end else dq_o = ~last;
   end
endmodule // frac_flash_model
`default_nettype wire

// *** frac_ctrl_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "frac_defs.vh"
module frac_ctrl_test;
   logic clk, rst_n, vld, rdy, rv, idm, oe, ce_n, oe_n, we_n;
   logic [2:0] op;
   logic [16:0] ad, fa;
   logic [7:0] dt, rd, rid, fdo, fdi;
   int bad_count = 0;
   int n_tests = 0;
   ////////////////////////////////////////////////////////////////
   frac_ctrl dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(vld), .REQ_OP_I(op), .REQ_ADDR_I(ad),
      .REQ_DATA_I(dt), .REQ_READY_O(rdy), .RSP_VALID_O(rv), .RSP_DATA_O(rd), .RSP_DEV_ID_O(rid),
      .ID_MODE_O(idm), .FL_ADDR_O(fa), .FL_DQ_O(fdo), .FL_DQ_OE_O(oe), .FL_DQ_I(fdi),
      .FL_CE_N_O(ce_n), .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n));
   frac_flash_model flash (.addr_i(fa), .dq_i(fdo), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_o(fdi));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic do_op(input logic [2:0] o, input logic [16:0] a, input logic [7:0] d);
      int n;
      vld <= 1'b1;
      op <= o;
      ad <= a;
      dt <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 100);
      vld <= 1'b0;
      if (rdy !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rv !== 1'b1 && n < 100);
      if (rv !== 1'b1) begin
         bad_count++;
         report_and_stop();
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_power_up;
      do_op(`FRAC_OP_READ, 17'h00005, 8'h00);
      check(rd, 8'hA0);
   endtask
   task automatic t_program;
      do_op(`FRAC_OP_PROGRAM, 17'h0000A, 8'h0F);
      do_op(`FRAC_OP_RESET, 17'h0000A, 8'h00);
      do_op(`FRAC_OP_READ, 17'h0000A, 8'h00);
      check(rd, 8'h0F);
   endtask
   task automatic t_setup_reset;
      do_op(`FRAC_OP_WRITE, 17'h00003, 8'h40);
      do_op(`FRAC_OP_RESET, 17'h00003, 8'h00);
      do_op(`FRAC_OP_READ, 17'h00003, 8'h00);
      check(rd, 8'hA6);
      do_op(`FRAC_OP_RESET, 17'h00004, 8'h00);
      do_op(`FRAC_OP_READ, 17'h00004, 8'h00);
      check(rd, 8'hA1);
   endtask
   task automatic t_identify;
      do_op(`FRAC_OP_READ_ID, 17'h00000, 8'h00);
      check(rd, 8'hA7);
      check(rid, 8'h3C);
      check({7'h00, idm}, 8'h01);
      do_op(`FRAC_OP_WRITE, 17'h00000, 8'h55);
      do_op(`FRAC_OP_READ, 17'h00001, 8'h00);
      check(rd, 8'h3C);
      check({7'h00, idm}, 8'h01);
      do_op(`FRAC_OP_WRITE, 17'h00000, 8'hFF);
      check({7'h00, idm}, 8'h00);
      do_op(`FRAC_OP_WRITE, 17'h00000, 8'h80);
      check({7'h00, idm}, 8'h01);
      do_op(`FRAC_OP_WRITE, 17'h00000, 8'h40);
      check({7'h00, idm}, 8'h00);
      do_op(`FRAC_OP_RESET, 17'h00000, 8'h00);
      do_op(`FRAC_OP_READ, 17'h00000, 8'h00);
      check(rd, 8'hA5);
      check({7'h00, idm}, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      vld = 1'b0;
      op = 3'h0;
      ad = 17'h00000;
      dt = 8'h00;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_power_up();
      t_program();
      t_setup_reset();
      t_identify();
      report_and_stop();
   end
endmodule // frac_ctrl_test
bind frac_ctrl frac_props u_props (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .REQ_VALID_I(REQ_VALID_I),
   .REQ_READY_O(REQ_READY_O), .RSP_VALID_O(RSP_VALID_O), .ID_MODE_O(ID_MODE_O), .FL_ADDR_O(FL_ADDR_O),
   .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_O(FL_DQ_OE_O), .FL_CE_N_O(FL_CE_N_O), .FL_OE_N_O(FL_OE_N_O),
   .FL_WE_N_O(FL_WE_N_O));
`default_nettype wire
